// file: hw/mide_core.sv
/*
 * Instruction decode and execute core: four-phase instruction cycle,
 * read-modify-write of data registers, status flags, call stack and a
 * small control port.
 * Assumes program memory returns the word for pc_o combinationally and
 * the data register file answers a read strobe one cycle later.
 */
// Added by the designer: the address-and-strobe port and the register offsets.
// Notes on behaviour
// - instruction is one 14-bit word, opcode plus operands
// - each word falls into exactly one class
// - destination bit picks accumulator or register
// - register address spans 0x00 to 0x7F
// - bit select picks one of eight bits
// - literals are 8 bits, targets 11 bits
// - one instruction cycle is four clocks
// - taken skip or branch adds a NOP cycle
// - named register is always read first
// - port read clears the pin-change mismatch
// - don't-care opcode bits are ignored
// - port self-modify uses pin levels
// - timer write clears assigned prescaler
`timescale 1ns/100ps
module mide_core
    import mide_pkg::*;
#(
    parameter int PC_W = 13,
    parameter int STACK_DEPTH = 8
) (
    input wire logic sys_clk_i,
    input wire logic rst_n_i,
    output logic [PC_W-1:0] pc_o,
    input wire logic [INSTR_W-1:0] instr_i,
    output logic [FADDR_W-1:0] fr_addr_o,
    output logic fr_rd_o,
    input wire logic [DATA_W-1:0] fr_rdata_i,
    output logic fr_wr_o,
    output logic [DATA_W-1:0] fr_wdata_o,
    input wire logic [DATA_W-1:0] pins_i,
    output logic port_rd_o,
    input wire logic psa_t0_i,
    output logic prescaler_clr_o,
    input wire logic wdt_expire_i,
    input wire logic wake_i,
    output logic wdt_clr_o,
    output logic sleep_o,
    output logic cyc_o,
    output logic [DATA_W-1:0] w_o,
    output logic carry_o,
    output logic nibble_overflow_flag_o,
    output logic zero_o,
    output logic expiry_flag_o,
    output logic sleep_entered_flag_o,
    input wire logic [REG_ADDR_W-1:0] reg_addr_i,
    input wire logic [DATA_W-1:0] reg_wdata_i,
    input wire logic reg_wr_i,
    input wire logic reg_rd_i,
    output logic [DATA_W-1:0] reg_rdata_o
);
    localparam int SP_W = $clog2(STACK_DEPTH);

    // refuse shapes the jump and stack logic cannot serve
    if (PC_W <= K11_W || PC_W > 16) begin : g_pc_chk
        $error("PC_W must lie between 12 and 16");
    end
    if (STACK_DEPTH < 2 || (1 << SP_W) != STACK_DEPTH) begin : g_stk_chk
        $error("STACK_DEPTH must be a power of two of at least 2");
    end

    typedef struct packed {
        mide_phase_t ph;
        logic flush;
        logic run;
        logic sleeping;
        logic [PC_W-1:0] pc;
        logic [INSTR_W-1:0] ir;
        logic [DATA_W-1:0] opnd;
        logic [DATA_W-1:0] w;
        logic c;
        logic dc;
        logic z;
        logic expiry;
        logic slp;
        logic [SP_W-1:0] sp;
        logic [STACK_DEPTH-1:0][PC_W-1:0] stk;
        logic [FADDR_W-1:0] fr_addr;
        logic fr_rd;
        logic fr_wr;
        logic [DATA_W-1:0] fr_wdata;
        logic port_rd;
        logic psc_clr;
        logic wdt_clr;
        logic cyc;
        logic [DATA_W-1:0] rdata;
    } mide_st_t;

    mide_st_t st_q;
    mide_st_t st_d;
    mide_dec_t dv;

    mide_dec_if dec_if ();

    // in Q1 the fresh word is decoded so the register read can go out
    assign dec_if.instr = (st_q.ph == PH_Q1) ? instr_i : st_q.ir;
    assign dv = dec_if.dec;

    mide_decode u_dec (
        .dif(dec_if)
    );

    // datapath and sequencing
    always_comb begin
        logic [DATA_W-1:0] a;
        logic [DATA_W-1:0] bop;
        logic [DATA_W-1:0] msk;
        logic [DATA_W-1:0] res;
        logic [DATA_W:0] s9;
        logic [4:0] s5;
        logic cin;
        logic cy;
        logic sk;
        logic [PC_W-1:0] pc_inc;
        a = dv.use_lit ? dv.k8 : st_q.opnd;
        cin = (dv.alu == ALU_SUB);
        // subtract as a plus complement plus one, carry means no borrow
        bop = cin ? ~st_q.w : st_q.w;
        s9 = {1'b0, a} + {1'b0, bop} + {8'h00, cin};
        s5 = {1'b0, a[3:0]} + {1'b0, bop[3:0]} + {4'h0, cin};
        msk = 8'h01 << dv.bsel;
        cy = st_q.c;
        res = a;
        case (dv.alu)
            ALU_MOVW: res = st_q.w;
            ALU_CLR: res = 8'h00;
            ALU_SUB, ALU_ADD: begin
                res = s9[DATA_W-1:0];
                cy = s9[DATA_W];
            end
            ALU_DEC: res = a - 8'h01;
            ALU_IOR: res = a | st_q.w;
            ALU_AND: res = a & st_q.w;
            ALU_XOR: res = a ^ st_q.w;
            ALU_COM: res = ~a;
            ALU_INC: res = a + 8'h01;
            ALU_BCLR: res = a & ~msk;
            ALU_BSET: res = a | msk;
            ALU_RR: begin
                res = {st_q.c, a[DATA_W-1:1]};
                cy = a[0];
            end
            ALU_RL: begin
                res = {a[DATA_W-2:0], st_q.c};
                cy = a[DATA_W-1];
            end
            ALU_SWAP: res = {a[3:0], a[7:4]};
            default: res = a;
        endcase
        sk = (dv.skip_zero && res == 8'h00)
            || (dv.skip_clr && !a[dv.bsel])
            || (dv.skip_set && a[dv.bsel]);
        pc_inc = PC_W'(st_q.pc + PC_W'(1));

        st_d = st_q;
        st_d.fr_rd = 1'b0;
        st_d.fr_wr = 1'b0;
        st_d.port_rd = 1'b0;
        st_d.psc_clr = 1'b0;
        st_d.wdt_clr = 1'b0;
        st_d.cyc = 1'b0;
        st_d.rdata = 8'h00;
        // wake only drops sleep; a sleep executed in this cycle still wins
        if (wake_i) begin
            st_d.sleeping = 1'b0;
        end

        case (st_q.ph)
            PH_Q1: begin
                // a halted or sleeping core parks here between cycles
                if (st_q.run && !st_q.sleeping) begin
                    st_d.ir = instr_i;
                    st_d.ph = PH_Q2;
                    st_d.fr_addr = dv.faddr;
                    // every register operand is read, even write-only ones
                    if (!st_q.flush && dv.uses_file) begin
                        st_d.fr_rd = 1'b1;
                        st_d.port_rd = (dv.faddr == PORT_ADDR);
                    end
                end
            end
            PH_Q2: st_d.ph = PH_Q3;
            PH_Q3: begin
                st_d.ph = PH_Q4;
                // port operand comes from the pins, not the latch
                st_d.opnd = (st_q.fr_addr == PORT_ADDR) ? pins_i : fr_rdata_i;
            end
            PH_Q4: begin
                st_d.ph = PH_Q1;
                st_d.cyc = 1'b1;
                if (st_q.flush) begin
                    // pc already holds the new target, nothing else moves
                    st_d.flush = 1'b0;
                end else begin
                    if (dv.dst_w) begin
                        st_d.w = res;
                    end
                    if (dv.dst_f) begin
                        st_d.fr_wr = 1'b1;
                        st_d.fr_wdata = res;
                        st_d.psc_clr = psa_t0_i && (st_q.fr_addr == TIMER0_ADDR);
                    end
                    if (dv.aff_z) begin
                        st_d.z = (res == 8'h00);
                    end
                    if (dv.aff_c) begin
                        st_d.c = cy;
                    end
                    if (dv.aff_dc) begin
                        st_d.dc = s5[4];
                    end
                    st_d.pc = pc_inc;
                    if (sk) begin
                        st_d.pc = PC_W'(pc_inc + PC_W'(1));
                        st_d.flush = 1'b1;
                    end
                    // page bits above the 11-bit target are kept
                    if (dv.jump || dv.call) begin
                        st_d.pc = {st_q.pc[PC_W-1:K11_W], dv.k11};
                        st_d.flush = 1'b1;
                    end
                    // stack wraps silently on overflow and underflow
                    if (dv.call) begin
                        st_d.stk[st_q.sp] = pc_inc;
                        st_d.sp = SP_W'(st_q.sp + SP_W'(1));
                    end
                    if (dv.ret) begin
                        st_d.sp = SP_W'(st_q.sp - SP_W'(1));
                        st_d.pc = st_q.stk[SP_W'(st_q.sp - SP_W'(1))];
                        st_d.flush = 1'b1;
                    end
                    if (dv.clrwdt) begin
                        st_d.expiry = 1'b0;
                        st_d.slp = 1'b0;
                        st_d.wdt_clr = 1'b1;
                    end
                    if (dv.sleep) begin
                        st_d.expiry = 1'b0;
                        st_d.slp = 1'b1;
                        st_d.wdt_clr = 1'b1;
                        st_d.sleeping = 1'b1;
                    end
                end
            end
            default: st_d.ph = PH_Q1;
        endcase

        // watchdog expiry wins over a same-cycle clear
        if (wdt_expire_i) begin
            st_d.expiry = 1'b1;
        end
        // control port: run enable writable, state readable
        if (reg_wr_i && reg_addr_i == REG_CTRL) begin
            st_d.run = reg_wdata_i[CTRL_RUN_BIT];
        end
        if (reg_rd_i) begin
            case (reg_addr_i)
                REG_CTRL: st_d.rdata[CTRL_RUN_BIT] = st_q.run;
                REG_STATUS: begin
                    st_d.rdata[ST_C_BIT] = st_q.c;
                    st_d.rdata[ST_DC_BIT] = st_q.dc;
                    st_d.rdata[ST_Z_BIT] = st_q.z;
                    st_d.rdata[ST_SLP_BIT] = st_q.slp;
                    st_d.rdata[ST_EXP_BIT] = st_q.expiry;
                end
                REG_WREG: st_d.rdata = st_q.w;
                REG_PCL: st_d.rdata = st_q.pc[DATA_W-1:0];
                default: st_d.rdata = 8'h00;
            endcase
        end
    end

    // single state register
    always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            st_q <= '0;
            st_q.run <= CTRL_RUN_RST;
        end else begin
            st_q <= st_d;
        end
    end

    assign pc_o = st_q.pc;
    assign fr_addr_o = st_q.fr_addr;
    assign fr_rd_o = st_q.fr_rd;
    assign fr_wr_o = st_q.fr_wr;
    assign fr_wdata_o = st_q.fr_wdata;
    assign port_rd_o = st_q.port_rd;
    assign prescaler_clr_o = st_q.psc_clr;
    assign wdt_clr_o = st_q.wdt_clr;
    assign sleep_o = st_q.sleeping;
    assign cyc_o = st_q.cyc;
    assign w_o = st_q.w;
    assign carry_o = st_q.c;
    assign nibble_overflow_flag_o = st_q.dc;
    assign zero_o = st_q.z;
    assign expiry_flag_o = st_q.expiry;
    assign sleep_entered_flag_o = st_q.slp;
    assign reg_rdata_o = st_q.rdata;

    // checks on the core's own behaviour
    default clocking cb @(posedge sys_clk_i);
    endclocking
    default disable iff (!rst_n_i);

    property p_cycle_len;
        cyc_o |=> !cyc_o [*3];
    endproperty
    a_cycle_len: assert property (p_cycle_len)
        else $error("instruction cycle shorter than four clocks");

    property p_rmw_read;
        fr_wr_o |-> $past(fr_rd_o, 3) && $past(fr_addr_o, 3) == fr_addr_o;
    endproperty
    a_rmw_read: assert property (p_rmw_read)
        else $error("register written without the read three clocks before");

    property p_port_read;
        port_rd_o |-> fr_rd_o && fr_addr_o == PORT_ADDR;
    endproperty
    a_port_read: assert property (p_port_read)
        else $error("port read pulse without a port register read");

    property p_psc_clr;
        prescaler_clr_o |-> fr_wr_o && fr_addr_o == TIMER0_ADDR && $past(psa_t0_i);
    endproperty
    a_psc_clr: assert property (p_psc_clr)
        else $error("prescaler cleared without a timer write");

    property p_flush_quiet;
        st_q.flush |=> $stable(st_q.w) && $stable({st_q.c, st_q.dc, st_q.z}) && !fr_rd_o;
    endproperty
    a_flush_quiet: assert property (p_flush_quiet)
        else $error("flushed cycle changed state or read a register");

    property p_dest_w;
        st_q.ph == PH_Q4 && !st_q.flush && dv.cls == CLS_BYTE && !st_q.ir[DEST_BIT]
            |=> !fr_wr_o;
    endproperty
    a_dest_w: assert property (p_dest_w)
        else $error("destination 0 still wrote the register");

    property p_dest_f;
        st_q.ph == PH_Q4 && !st_q.flush && dv.cls == CLS_BYTE && st_q.ir[DEST_BIT]
            |=> fr_wr_o ##0 $stable(st_q.w);
    endproperty
    a_dest_f: assert property (p_dest_f)
        else $error("destination 1 did not write the register");

    property p_flags_hold;
        st_q.ph != PH_Q4 |=> $stable({st_q.c, st_q.dc, st_q.z});
    endproperty
    a_flags_hold: assert property (p_flags_hold)
        else $error("arithmetic flags changed outside execution");

    property p_branch_two;
        st_q.ph == PH_Q4 && !st_q.flush && (dv.jump || dv.call || dv.ret)
            |=> st_q.flush ##4 !st_q.flush [*1];
    endproperty
    a_branch_two: assert property (p_branch_two)
        else $error("branch did not add exactly one flushed cycle");

    property p_lit_dontcare;
        st_q.ph != PH_Q1 && st_q.ir[CLS_HI:OPC_HI-1] == 4'b1100 |-> dv.alu == ALU_MOVA;
    endproperty
    a_lit_dontcare: assert property (p_lit_dontcare)
        else $error("literal load decode depends on a don't-care bit");

    c_skip: cover property (st_q.ph == PH_Q4 && !st_q.flush && dv.skip_zero ##1 st_q.flush);
    c_port: cover property (port_rd_o ##3 fr_wr_o);
    c_psc: cover property (prescaler_clr_o);
    c_call_ret: cover property (st_q.ph == PH_Q4 && dv.ret && !st_q.flush && st_q.sp != '0);
endmodule

// file: pkg/mide_pkg.sv
/*
 * Shared constants and types of the instruction decode and execute core:
 * word layout, special register addresses, control port map, phase and
 * operation encodings, and the decoded-instruction record.
 * Assumes a 14-bit program word and 8-bit data registers.
 */
package mide_pkg;
    localparam int INSTR_W = 14;
    localparam int DATA_W = 8;
    localparam int FADDR_W = 7;
    localparam int K11_W = 11;
    localparam int BSEL_W = 3;
    localparam int OSC_PER_CYCLE = 4;
    // field positions inside the instruction word
    localparam int CLS_HI = 13;
    localparam int CLS_LO = 12;
    localparam int OPC_HI = 11;
    localparam int OPC_LO = 8;
    localparam int DEST_BIT = 7;
    localparam int BSEL_HI = 9;
    localparam int BSEL_LO = 7;
    localparam int CTLZ_HI = 11;
    localparam int CTLZ_LO = 7;
    // fixed control words
    localparam logic [INSTR_W-1:0] OP_RETURN = 14'h0008;
    localparam logic [INSTR_W-1:0] OP_RETFIE = 14'h0009;
    localparam logic [INSTR_W-1:0] OP_SLEEP = 14'h0063;
    localparam logic [INSTR_W-1:0] OP_CLRWDT = 14'h0064;
    // data register addresses with side effects
    localparam logic [FADDR_W-1:0] TIMER0_ADDR = 7'h01;
    localparam logic [FADDR_W-1:0] PORT_ADDR = 7'h05;
    // control port map
    localparam int REG_ADDR_W = 2;
    localparam logic [REG_ADDR_W-1:0] REG_CTRL = 2'h0;
    localparam logic [REG_ADDR_W-1:0] REG_STATUS = 2'h1;
    localparam logic [REG_ADDR_W-1:0] REG_WREG = 2'h2;
    localparam logic [REG_ADDR_W-1:0] REG_PCL = 2'h3;
    localparam int CTRL_RUN_BIT = 0;
    localparam logic CTRL_RUN_RST = 1'b1;
    localparam int ST_C_BIT = 0;
    localparam int ST_DC_BIT = 1;
    localparam int ST_Z_BIT = 2;
    localparam int ST_SLP_BIT = 3;
    localparam int ST_EXP_BIT = 4;

    typedef enum logic [1:0] {
        PH_Q1 = 2'b00,
        PH_Q2 = 2'b01,
        PH_Q3 = 2'b10,
        PH_Q4 = 2'b11
    } mide_phase_t;

    typedef enum logic [1:0] {
        CLS_BYTE = 2'b00,
        CLS_BIT = 2'b01,
        CLS_LIT = 2'b10
    } mide_cls_t;

    // codes match the byte-oriented opcode field where one exists
    typedef enum logic [3:0] {
        ALU_MOVW = 4'h0, ALU_CLR = 4'h1, ALU_SUB = 4'h2, ALU_DEC = 4'h3,
        ALU_IOR = 4'h4, ALU_AND = 4'h5, ALU_XOR = 4'h6, ALU_ADD = 4'h7,
        ALU_MOVA = 4'h8, ALU_COM = 4'h9, ALU_INC = 4'ha, ALU_BCLR = 4'hb,
        ALU_RR = 4'hc, ALU_RL = 4'hd, ALU_SWAP = 4'he, ALU_BSET = 4'hf
    } mide_alu_t;

    typedef struct packed {
        mide_cls_t cls;
        mide_alu_t alu;
        logic use_lit;
        logic uses_file;
        logic dst_w;
        logic dst_f;
        logic aff_z;
        logic aff_c;
        logic aff_dc;
        logic skip_zero;
        logic skip_clr;
        logic skip_set;
        logic jump;
        logic call;
        logic ret;
        logic sleep;
        logic clrwdt;
        logic [FADDR_W-1:0] faddr;
        logic [BSEL_W-1:0] bsel;
        logic [DATA_W-1:0] k8;
        logic [K11_W-1:0] k11;
    } mide_dec_t;
endpackage

// file: pkg/mide_dec_if.sv
/*
 * Carrier between the core and its decoder: the word to decode and the
 * decoded record. Purely combinational, no clock.
 */
`timescale 1ns/100ps
interface mide_dec_if;
    import mide_pkg::*;
    logic [INSTR_W-1:0] instr;
    mide_dec_t dec;
    modport drv (input instr, output dec);
    modport usr (output instr, input dec);
endinterface

// file: hw/mide_decode.sv
/*
 * Combinational instruction decoder: sorts a 14-bit word into one of
 * three classes and extracts its operand fields.
 * Assumes the word is stable for as long as the record is used.
 */
`timescale 1ns/100ps
module mide_decode
    import mide_pkg::*;
(
    mide_dec_if.drv dif
);
    // don't-care positions are never looked at, so 0 or 1 decode alike
    always_comb begin
        mide_dec_t d;
        logic [3:0] opc;
        d = '0;
        opc = dif.instr[OPC_HI:OPC_LO];
        d.faddr = dif.instr[FADDR_W-1:0];
        d.bsel = dif.instr[BSEL_HI:BSEL_LO];
        d.k8 = dif.instr[DATA_W-1:0];
        d.k11 = dif.instr[K11_W-1:0];
        d.alu = ALU_MOVA;
        case (dif.instr[CLS_HI:CLS_LO])
            2'b00: begin
                if (dif.instr[CTLZ_HI:CTLZ_LO] == 5'h00) begin
                    d.cls = CLS_LIT;
                    d.ret = (dif.instr == OP_RETURN) || (dif.instr == OP_RETFIE);
                    d.sleep = (dif.instr == OP_SLEEP);
                    d.clrwdt = (dif.instr == OP_CLRWDT);
                end else begin
                    d.cls = CLS_BYTE;
                    d.alu = (opc == 4'hb) ? ALU_DEC :
                            (opc == 4'hf) ? ALU_INC : mide_alu_t'(opc);
                    d.dst_f = dif.instr[DEST_BIT];
                    d.dst_w = !dif.instr[DEST_BIT];
                    // clear-W names no register, everything else reads f
                    d.uses_file = !(opc == 4'h1 && !dif.instr[DEST_BIT]);
                    d.aff_z = (opc >= 4'h1) && (opc <= 4'ha);
                    d.aff_c = (opc == 4'h2) || (opc == 4'h7) || (opc == 4'hc) || (opc == 4'hd);
                    d.aff_dc = (opc == 4'h2) || (opc == 4'h7);
                    d.skip_zero = (opc == 4'hb) || (opc == 4'hf);
                end
            end
            2'b01: begin
                d.cls = CLS_BIT;
                d.uses_file = 1'b1;
                case (opc[3:2])
                    2'b00: begin
                        d.alu = ALU_BCLR;
                        d.dst_f = 1'b1;
                    end
                    2'b01: begin
                        d.alu = ALU_BSET;
                        d.dst_f = 1'b1;
                    end
                    2'b10: d.skip_clr = 1'b1;
                    default: d.skip_set = 1'b1;
                endcase
            end
            2'b10: begin
                d.cls = CLS_LIT;
                d.jump = opc[3];
                d.call = !opc[3];
            end
            default: begin
                d.cls = CLS_LIT;
                d.use_lit = 1'b1;
                d.dst_w = 1'b1;
                casez (opc)
                    4'b00??: d.alu = ALU_MOVA;
                    4'b01??: begin
                        d.alu = ALU_MOVA;
                        d.ret = 1'b1;
                    end
                    4'b1000: d.alu = ALU_IOR;
                    4'b1001: d.alu = ALU_AND;
                    4'b1010: d.alu = ALU_XOR;
                    4'b110?: d.alu = ALU_SUB;
                    default: d.alu = ALU_ADD;
                endcase
                // only the literal loads, with or without return, leave zero alone
                d.aff_z = (d.alu != ALU_MOVA);
                if (d.alu == ALU_SUB || d.alu == ALU_ADD) begin
                    d.aff_z = 1'b1;
                    d.aff_c = 1'b1;
                    d.aff_dc = 1'b1;
                end
            end
        endcase
        dif.dec = d;
    end
endmodule

// file: verif/mide_prog_mem.sv
/*
 * program memory model: sixteen 14-bit words read by program address.
 * assumes the bench loads the words before reset is released.
 */
`timescale 1ns/100ps
module mide_prog_mem #(
    parameter int PC_W = 13
) (
    input wire logic [PC_W-1:0] pc_i,
    output logic [13:0] instr_o
);
    logic [13:0] mem [16];
    // whole words only, don't-care bits as loaded
    assign instr_o = (pc_i < 16) ? mem[pc_i[3:0]] : 14'h0000;
endmodule

// file: verif/mide_core_tb.sv
/*
 * self-checking bench of the core: program model, data register model
 * and an integer reference of each executed word.
 * assumes the four-clock cycle and cyc_o timing of the core.
 */
`timescale 1ns/100ps
module mide_core_tb;
    import mide_pkg::*;
    logic sys_clk_i = 0, rst_n_i = 0, fr_rd_o, fr_wr_o, port_rd_o, cyc_o;
    logic carry_o, nibble_overflow_flag_o, zero_o, reg_wr_i = 0, reg_rd_i = 0;
    logic psa_t0_i = 1, wdt_expire_i = 0, prescaler_clr_o, wdt_clr_o, sleep_o;
    logic expiry_flag_o, sleep_entered_flag_o;
    logic [12:0] pc_o;
    logic [13:0] instr_i;
    logic [6:0] fr_addr_o;
    logic [7:0] fr_rdata_i = 0, fr_wdata_o, pins_i, w_o, reg_rdata_o, reg_wdata_i = 0;
    logic [1:0] reg_addr_i = 0;
    logic [7:0] dram [128], mram [128], mw = 0, k1, k2;
    logic mc = 0, mdc = 0, mz = 0, flush = 0;
    int n_fail = 0, n_checks = 0, n_cyc = 0, gap = 0, n_port = 0, n_rd = 0, mpc = 0;
    int n_psc = 0, n_wclr = 0;
    int seed = 32'h6fda;
    mide_prog_mem u_prog_mem (.pc_i(pc_o), .instr_o(instr_i));
    mide_core u_mide_core (.sys_clk_i, .rst_n_i, .pc_o, .instr_i, .fr_addr_o, .fr_rd_o,
        .fr_rdata_i, .fr_wr_o, .fr_wdata_o, .pins_i, .port_rd_o, .psa_t0_i,
        .prescaler_clr_o, .wdt_expire_i, .wake_i(1'b0), .wdt_clr_o, .sleep_o,
        .cyc_o, .w_o, .carry_o, .nibble_overflow_flag_o, .zero_o, .expiry_flag_o,
        .sleep_entered_flag_o, .reg_addr_i, .reg_wdata_i, .reg_wr_i, .reg_rd_i,
        .reg_rdata_o);
    initial begin
        forever #12.5 sys_clk_i = ~sys_clk_i;
    end
    task automatic chk8(input string nm, input logic [7:0] e, input logic [7:0] g);
        n_checks++;
        if (g !== e) begin
            n_fail++;
            $display("[ERR] %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic tally_and_finish();
        if (n_fail == 0 && n_checks > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask
    // reference of one word; the port source is the pin level
    task automatic exec(input logic [13:0] i);
        logic [8:0] s;
        logic [7:0] v;
        v = (i[6:0] == PORT_ADDR) ? pins_i : mram[i[6:0]];
        mpc = mpc + 1;
        case (i[13:12])
            2'b11: if (i[11:10] == 2'b00) mw = i[7:0];
            else begin
                mdc = ({1'b0, mw[3:0]} + {1'b0, i[3:0]}) > 5'h0f;
                s = {1'b0, mw} + {1'b0, i[7:0]};
                mc = s[8];
                mw = s[7:0];
                mz = (mw == 8'h00);
            end
            2'b00: if (i[11:7] == 5'h01) mram[i[6:0]] = mw;
            else if (i[11:7] != 5'h00) begin
                v = (i[11:8] == 4'ha) ? v + 8'h01 : v;
                mz = (v == 8'h00);
                if (i[7]) mram[i[6:0]] = v;
                else mw = v;
            end
            2'b01: if (v[i[9:7]] == 1'b0) begin
                mpc = mpc + 1;
                flush = 1;
            end
            default: begin
                mpc = i[10:0];
                flush = 1;
            end
        endcase
    endtask
    // data registers answer one cycle after the strobe, else show inverted data
    always @(posedge sys_clk_i) begin
        fr_rdata_i <= fr_rd_o ? dram[fr_addr_o] : ~fr_rdata_i;
        if (fr_wr_o) dram[fr_addr_o] <= fr_wdata_o;
        if (fr_rd_o === 1'b1) n_rd++;
        if (port_rd_o === 1'b1) n_port++;
        if (prescaler_clr_o === 1'b1) n_psc++;
        if (wdt_clr_o === 1'b1) n_wclr++;
    end
    // compare at every cycle end; flushed cycles change nothing visible
    always @(negedge sys_clk_i) begin
        gap++;
        if (cyc_o === 1'b1) begin
            if (n_cyc > 0) chk8("cycle_len", 8'd4, 8'(gap));
            gap = 0;
            n_cyc++;
            if (flush) flush = 0;
            else begin
                exec(u_prog_mem.mem[mpc[3:0]]);
                chk8("w", mw, w_o);
                chk8("flags", {5'h0, mz, mdc, mc},
                    {5'h0, zero_o, nibble_overflow_flag_o, carry_o});
            end
        end
    end
    task automatic rd(input logic [1:0] a, input logic [7:0] e);
        @(posedge sys_clk_i);
        reg_rd_i <= 1;
        reg_addr_i <= a;
        @(posedge sys_clk_i);
        reg_rd_i <= 0;
        @(negedge sys_clk_i);
        chk8("reg_rdata", e, reg_rdata_o);
    endtask
    // watchdog well beyond the sixteen instruction cycles of the run
    initial begin
        repeat (2000) @(posedge sys_clk_i);
        n_fail++;
        tally_and_finish();
    end
    initial begin
        k1 = 8'($random(seed));
        k2 = 8'($random(seed));
        pins_i = 8'($random(seed));
        for (int j = 0; j < 128; j++) dram[j] = 8'h00;
        for (int j = 0; j < 16; j++) u_prog_mem.mem[j] = 14'h280a;
        u_prog_mem.mem[0] = {6'b110011, k1}; // don't-care bits set
        u_prog_mem.mem[1] = 14'h00a0;
        u_prog_mem.mem[2] = {6'b111111, k2}; // don't-care bit set
        u_prog_mem.mem[3] = 14'h0805;
        u_prog_mem.mem[4] = 14'h1820; // bit test, skip on random bit
        u_prog_mem.mem[5] = 14'h30a5;
        u_prog_mem.mem[6] = 14'h0aa0;
        u_prog_mem.mem[7] = 14'h0820;
        u_prog_mem.mem[8] = 14'h0081; // store to the timer count
        u_prog_mem.mem[9] = OP_CLRWDT;
        repeat (20) @(posedge sys_clk_i);
        rst_n_i <= 1;
        for (int t = 0; t < 200 && n_cyc < 16; t++) @(posedge sys_clk_i);
        chk8("port_reads", 8'd1, 8'(n_port));
        chk8("file_reads", 8'd6, 8'(n_rd));
        chk8("prescaler_clears", 8'd1, 8'(n_psc));
        chk8("wdt_clears", 8'd1, 8'(n_wclr));
        chk8("file_20", mram[32], dram[32]);
        @(posedge sys_clk_i);
        reg_wr_i <= 1;
        reg_addr_i <= REG_WREG;
        reg_wdata_i <= ~mw;
        wdt_expire_i <= 1;
        @(posedge sys_clk_i);
        reg_wr_i <= 0;
        wdt_expire_i <= 0;
        rd(REG_WREG, mw);
        rd(REG_STATUS, {3'h0, 1'b1, 1'b0, mz, mdc, mc});
        rd(REG_CTRL, {7'h0, CTRL_RUN_RST});
        rd(REG_PCL, 8'(mpc));
        chk8("wdt_flags", 8'h01, {5'h0, sleep_o, sleep_entered_flag_o, expiry_flag_o});
        tally_and_finish();
    end
endmodule
